// *** pkg/cam_clutch_pkg.sv ***
// constants and types for the cam clutch state machine
// Summary of operation
// (RULE1) reset to stop, enable field off
// (RULE2) enable zero returns to stop always
// (RULE3) lead pulse done moves to engaged
// (RULE4) disengage four returns to lead pulse
// (RULE5) disengage one two six go stop
// (RULE6) engage select checked only in stop
// (RULE7) engage zero leaves stop on enable
// (RULE8) engage one waits for clutch input
// (RULE9) engage two leaves on capture event
// (RULE10) master pulses count lead counter down; code counts up on negative pulses (master_dir_neg_in)
// (RULE11) load initial or cycle lead count
// (RULE12) zero lead count engages at once
// (RULE13) lead count sign sets pulse direction; code counts by master_dir_neg_in instead
// (RULE14) lead counter value is monitored
// (RULE15) overflow clears enable, forces stop
// (RULE16) disengage select checked only engaged
// (RULE17) software picks one of two four six
// (RULE18) disengage one on clutch input off
// (RULE19) signed counter, overflow on wrap
// (RULE20) cam follows pulses only when engaged
package cam_clutch_pkg;
	localparam int LEAD_W = 32;
	localparam int SEL_W  = 4;

	localparam logic [SEL_W-1:0] ENG_IMMEDIATE = 4'h0;
	localparam logic [SEL_W-1:0] ENG_DIGITAL   = 4'h1;
	localparam logic [SEL_W-1:0] ENG_CAPTURE   = 4'h2;

	localparam logic [SEL_W-1:0] DIS_NONE      = 4'h0;
	localparam logic [SEL_W-1:0] DIS_DIGITAL   = 4'h1;
	localparam logic [SEL_W-1:0] DIS_COUNT     = 4'h2;
	localparam logic [SEL_W-1:0] DIS_CYCLE     = 4'h4;
	localparam logic [SEL_W-1:0] DIS_SMOOTH    = 4'h6;

	typedef enum logic [1:0]
	{
		ST_STOP    = 2'h0,
		ST_LEAD    = 2'h1,
		ST_ENGAGED = 2'h3
	} clutch_state_e;
endpackage

// *** verilog/cam_clutch_state_machine.sv ***
// cam clutch state machine with lead-pulse counter
`timescale 1ns/1ps
module cam_clutch_state_machine
(
	input  wire logic                                mclk_in,
	input  wire logic                                rst_b_in,
	input  wire logic                                enable_set_in,
	input  wire logic                                enable_clear_in,
	input  wire logic [cam_clutch_pkg::SEL_W-1:0]    engage_condition_select_in,
	input  wire logic [cam_clutch_pkg::SEL_W-1:0]    disengage_condition_select_in,
	input  wire logic signed [cam_clutch_pkg::LEAD_W-1:0] initial_lead_count_in,
	input  wire logic signed [cam_clutch_pkg::LEAD_W-1:0] cycle_lead_count_in,
	input  wire logic                                digital_input_in,
	input  wire logic                                capture_event_in,
	input  wire logic                                master_pulse_in,
	input  wire logic                                master_dir_neg_in,
	input  wire logic                                disengage_done_in,
	output logic                                     cam_enable_field_out,
	output logic [1:0]                               clutch_state_out,
	output logic signed [cam_clutch_pkg::LEAD_W-1:0] lead_count_monitor_out,
	output logic                                     cam_pulse_out,
	output logic                                     cam_dir_neg_out,
	output logic                                     overflow_out
);
	import cam_clutch_pkg::*;

	clutch_state_e                state_q;
	clutch_state_e                state_d;
	logic                         enable_q;
	logic signed [LEAD_W-1:0]     lead_q;
	logic signed [LEAD_W-1:0]     lead_d;
	logic                         ovf_d;
	logic                         ovf_hit;
	logic [2:0]                   din_sync_q;
	logic                         din_level_q;
	logic                         din_on;
	logic                         disengage_hit;
	logic signed [LEAD_W-1:0]     step;
	logic signed [LEAD_W-1:0]     lead_next;

	// clutch input: three flops, change counts once last two agree
	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
			din_sync_q <= 3'h0;
		else
			din_sync_q <= {din_sync_q[1:0], digital_input_in};
	end

	// accepted level of the clutch input
	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
			din_level_q <= 1'b0;
		else if (din_sync_q[2] == din_sync_q[1])
			din_level_q <= din_sync_q[2];
	end

	assign din_on = din_level_q;

	// decrement on forward master pulses, increment on negative ones (master_dir_neg_in)
	always_comb
	begin
		step = master_dir_neg_in ? -LEAD_W'(1) : LEAD_W'(1); // RULE13
		lead_next = lead_q - step; // RULE10
	end

	// signed wrap-around of the subtraction
	always_comb
	begin
		ovf_d = master_pulse_in && (lead_q[LEAD_W-1] != step[LEAD_W-1])
			&& (lead_next[LEAD_W-1] != lead_q[LEAD_W-1]); // RULE19
	end

	assign ovf_hit = (state_q == ST_LEAD) && ovf_d; // RULE15

	// count-based disengage selections
	function automatic logic is_count_disengage(input logic [SEL_W-1:0] sel);
		is_count_disengage = (sel == DIS_COUNT) || (sel == DIS_CYCLE) || (sel == DIS_SMOOTH);
	endfunction

	// engage condition, looked at only in stop
	function automatic logic engage_ready(input logic [SEL_W-1:0] sel, input logic din, input logic cap);
		engage_ready = (sel == ENG_IMMEDIATE) // RULE7
			|| (sel == ENG_DIGITAL && din) // RULE8
			|| (sel == ENG_CAPTURE && cap); // RULE9
	endfunction

	always_comb
	begin
		disengage_hit = 1'b0;
		if (disengage_condition_select_in == DIS_DIGITAL)
			disengage_hit = !din_on; // RULE18
		else if (is_count_disengage(disengage_condition_select_in))
			disengage_hit = disengage_done_in;
	end

	always_comb
	begin
		state_d = state_q;
		lead_d  = lead_q;
		case (state_q)
			ST_STOP:
			begin
				// RULE6
				if (enable_q && engage_ready(engage_condition_select_in, din_on, capture_event_in))
				begin
					lead_d  = initial_lead_count_in; // RULE11
					state_d = (initial_lead_count_in == '0) ? ST_ENGAGED : ST_LEAD; // RULE12
				end
			end
			ST_LEAD:
			begin
				if (lead_q == '0)
					state_d = ST_ENGAGED; // RULE3
				else if (master_pulse_in)
				begin
					lead_d = lead_next; // RULE10
					if (lead_next == '0)
						state_d = ST_ENGAGED; // RULE3
				end
			end
			ST_ENGAGED:
			begin
				if (disengage_hit) // RULE16
				begin
					if (disengage_condition_select_in == DIS_CYCLE)
					begin
						lead_d  = cycle_lead_count_in; // RULE4 RULE11
						state_d = (cycle_lead_count_in == '0) ? ST_ENGAGED : ST_LEAD; // RULE12
					end
					else
						state_d = ST_STOP; // RULE5
				end
			end
			default:
				state_d = ST_STOP;
		endcase
		if (!enable_q || ovf_hit)
			state_d = ST_STOP; // RULE2 RULE15
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
			state_q <= ST_STOP; // RULE1
		else
			state_q <= state_d;
	end

	// counter freezes on overflow
	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
			lead_q <= '0;
		else if (!ovf_hit)
			lead_q <= lead_d;
	end

	// clear and overflow beat set
	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
			enable_q <= 1'b0; // RULE1
		else if (ovf_hit)
			enable_q <= 1'b0; // RULE15
		else if (enable_clear_in)
			enable_q <= 1'b0; // RULE2
		else if (enable_set_in)
			enable_q <= 1'b1; // RULE1
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
			overflow_out <= 1'b0;
		else
			overflow_out <= ovf_hit; // RULE15
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
			cam_pulse_out <= 1'b0;
		else
			cam_pulse_out <= (state_q == ST_ENGAGED) && master_pulse_in; // RULE20
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
			cam_dir_neg_out <= 1'b0;
		else
			cam_dir_neg_out <= master_dir_neg_in;
	end

	// registered copies for the outside
	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
			cam_enable_field_out <= 1'b0;
		else
			cam_enable_field_out <= enable_q;
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
			clutch_state_out <= 2'h0;
		else
			clutch_state_out <= state_q;
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
			lead_count_monitor_out <= '0;
		else
			lead_count_monitor_out <= lead_q; // RULE14
	end
endmodule // cam_clutch_state_machine

// *** bench/cam_clutch_asserts.sv ***
// cam clutch port checker
`timescale 1ns/1ps
module cam_clutch_asserts import cam_clutch_pkg::*;
(
	input wire logic mclk_in, rst_b_in, enable_clear_in, master_pulse_in, cam_enable_field_out, cam_pulse_out,
	input wire logic overflow_out,
	input wire logic [SEL_W-1:0] disengage_condition_select_in,
	input wire logic signed [LEAD_W-1:0] initial_lead_count_in, cycle_lead_count_in, lead_count_monitor_out,
	input wire logic [1:0] clutch_state_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);
	sequence s_in; clutch_state_out == 1 && $past(clutch_state_out) == 0; endsequence
	sequence s_re; clutch_state_out == 1 && $past(clutch_state_out) == 3; endsequence
	property p_rst; $rose(rst_b_in) |-> !cam_enable_field_out && clutch_state_out == 0; endproperty
	a_rst: assert property (p_rst) else $error("reset");
	property p_clr; enable_clear_in |-> ##[1:4] !cam_enable_field_out && clutch_state_out == 0; endproperty
	a_clr: assert property (p_clr) else $error("clear");
	property p_ini; s_in |-> lead_count_monitor_out == initial_lead_count_in && cam_enable_field_out; endproperty
	a_ini: assert property (p_ini) else $error("load");
	property p_cyc; s_re |-> lead_count_monitor_out == cycle_lead_count_in
		&& $past(disengage_condition_select_in) == 4; endproperty
	a_cyc: assert property (p_cyc) else $error("cycle");
	property p_zero; clutch_state_out == 1 && lead_count_monitor_out == 0 |=> clutch_state_out != 1; endproperty
	a_zero: assert property (p_zero) else $error("zero");
	property p_stop; clutch_state_out == 0 && $past(clutch_state_out) == 3 |-> !cam_enable_field_out
		|| $past(disengage_condition_select_in) inside {1, 2, 6}; endproperty
	a_stop: assert property (p_stop) else $error("stop");
	property p_ovf; overflow_out |-> ##[0:2] !cam_enable_field_out && clutch_state_out == 0; endproperty
	a_ovf: assert property (p_ovf) else $error("overflow");
	property p_fol; cam_pulse_out |-> ($past(master_pulse_in) || $past(master_pulse_in, 2))
		&& (clutch_state_out == 3 || $past(clutch_state_out) == 3); endproperty
	a_fol: assert property (p_fol) else $error("follow");
endmodule // cam_clutch_asserts
bind cam_clutch_state_machine cam_clutch_asserts u_cam_clutch_asserts (.*);

// *** bench/master_axis_model.sv ***
// master axis pulse source
`timescale 1ns/1ps
module master_axis_model
(
	input  wire logic       mclk_in, go_in, neg_in,
	input  wire logic [7:0] n_in,
	output logic            pulse_out = 0,
	output logic            dir_neg_out = 0
);
	logic [7:0] left_q = 0;
	always @(posedge mclk_in)
	begin
		left_q <= go_in ? n_in : left_q - 8'(left_q != 0);
		pulse_out <= left_q != 0;
		dir_neg_out <= left_q != 0 ? neg_in : !dir_neg_out;
	end
endmodule // master_axis_model

// *** bench/cam_clutch_state_machine_test.sv ***
// cam clutch bench
`timescale 1ns/1ps
module cam_clutch_state_machine_test;
	import cam_clutch_pkg::*;
	logic mclk_in = 0, rst_b_in = 0, enable_set_in = 0, enable_clear_in = 0, digital_input_in = 0, go = 0, neg = 0;
	logic capture_event_in = 0, disengage_done_in = 0, master_pulse_in, master_dir_neg_in;
	logic cam_enable_field_out, cam_pulse_out, cam_dir_neg_out, overflow_out;
	logic [SEL_W-1:0] engage_condition_select_in = 0, disengage_condition_select_in = 0;
	logic signed [LEAD_W-1:0] initial_lead_count_in = 0, cycle_lead_count_in = 0, lead_count_monitor_out;
	logic [1:0] clutch_state_out;
	logic [7:0] n = 0;
	int n_fail = 0, cmp_count = 0, n_cam = 0, n_ovf = 0;
	logic cam_dir_q = 0;
	always #5 mclk_in = ~mclk_in;
	always @(posedge mclk_in)
	begin
		if (cam_pulse_out === 1'b1)
		begin
			n_cam <= n_cam + 1;
			cam_dir_q <= cam_dir_neg_out;
		end
		if (overflow_out === 1'b1)
			n_ovf <= n_ovf + 1;
	end
	cam_clutch_state_machine u_cam_clutch_state_machine (.*);
	master_axis_model u_master_axis_model (.mclk_in, .go_in(go), .neg_in(neg), .n_in(n),
		.pulse_out(master_pulse_in), .dir_neg_out(master_dir_neg_in));
	task automatic chk(input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic clk(input int k);
		repeat (k) @(posedge mclk_in);
	endtask
	task automatic st(input logic [1:0] s);
		@(negedge mclk_in);
		for (int i = 0; i < 50 && clutch_state_out !== s; i++)
			@(negedge mclk_in);
		chk(clutch_state_out, s);
	endtask
	task automatic en(input logic v);
		clk(1);
		enable_set_in <= v;
		enable_clear_in <= !v;
		clk(1);
		enable_set_in <= 0;
		enable_clear_in <= 0;
	endtask
	task automatic kick(input logic cap);
		clk(1);
		capture_event_in <= cap;
		disengage_done_in <= !cap;
		clk(1);
		capture_event_in <= 0;
		disengage_done_in <= 0;
	endtask
	task automatic pulses(input logic [7:0] k, input logic d);
		clk(1);
		n <= k;
		neg <= d;
		go <= 1;
		clk(1);
		go <= 0;
		clk(k + 3);
		@(negedge mclk_in);
	endtask
	task automatic t_lead;
		int base;
		clk(1);
		initial_lead_count_in <= 3;
		en(1);
		st(1);
		chk(lead_count_monitor_out, 3);
		base = n_cam;
		pulses(2, 0);
		chk(lead_count_monitor_out, 1);
		chk(n_cam - base, 0);
		pulses(1, 0);
		st(3);
		base = n_cam;
		pulses(2, 1);
		chk(n_cam - base, 2);
		chk(cam_dir_q, 1);
		en(0);
		st(0);
		$display("lead test end");
	endtask
	task automatic t_dig;
		clk(1);
		engage_condition_select_in <= ENG_DIGITAL;
		disengage_condition_select_in <= DIS_DIGITAL;
		initial_lead_count_in <= 0;
		en(1);
		clk(8);
		st(0);
		clk(1);
		digital_input_in <= 1;
		st(3);
		clk(1);
		digital_input_in <= 0;
		st(0);
		en(0);
		$display("input test end");
	endtask
	task automatic t_cap;
		clk(1);
		engage_condition_select_in <= ENG_CAPTURE;
		disengage_condition_select_in <= DIS_CYCLE;
		cycle_lead_count_in <= 2;
		en(1);
		clk(6);
		st(0);
		kick(1);
		st(3);
		kick(0);
		st(1);
		chk(lead_count_monitor_out, 2);
		pulses(2, 0);
		st(3);
		clk(1);
		engage_condition_select_in <= ENG_DIGITAL;
		disengage_condition_select_in <= DIS_SMOOTH;
		kick(0);
		st(0);
		en(0);
		$display("capture test end");
	endtask
	task automatic t_ovf;
		clk(1);
		engage_condition_select_in <= ENG_IMMEDIATE;
		disengage_condition_select_in <= DIS_NONE;
		initial_lead_count_in <= 32'sh7fff_fffe;
		en(1);
		st(1);
		pulses(3, 1);
		st(0);
		chk(cam_enable_field_out, 0);
		chk(n_ovf, 1);
		chk(lead_count_monitor_out, 32'h7fff_ffff);
		$display("overflow test end");
	endtask
	task automatic test_done;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		clk(2);
		rst_b_in <= 1;
		@(negedge mclk_in);
		chk(cam_enable_field_out, 0);
		t_lead();
		t_dig();
		t_cap();
		t_ovf();
		test_done();
	end
	initial
	begin
		#20us;
		n_fail++;
		test_done();
	end
endmodule // cam_clutch_state_machine_test
